//--- pkg/serial_port_defs.svh
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// ==========================================================================
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_DATA 8'h08
`define OFS_PINS 8'h0c

// ==========================================================================
// reset values and writable masks
`define CTRL_RST 8'h00
`define CTRL_MASK 8'hf3
`define PINS_RST 8'h10
`define PINS_MASK 8'h1f

// ==========================================================================
// status register layout
`define STAT_FLAG 7
`define STAT_WCOL 6
`define STAT_DBL 0

// ==========================================================================
// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ==========================================================================
// bits per byte and half periods of the serial clock in cpu cycles
`define BYTE_BITS 4'd8
`define LAST_BIT 4'd7
`define HALF_N0 7'd2
`define HALF_N1 7'd8
`define HALF_N2 7'd32
`define HALF_N3 7'd64
`define HALF_D0 7'd1
`define HALF_D1 7'd4
`define HALF_D2 7'd16
`define HALF_D3 7'd32

`endif

//--- pkg/serial_port_pkg.sv
package serial_port_pkg;

    // control register fields
    typedef struct packed {
        logic irq_en;
        logic enable;
        logic lsb_first;
        logic master;
        logic [1:0] rsvd;
        logic [1:0] rate;
    } ctrl_t;

    // pin direction and select level register fields
    typedef struct packed {
        logic [2:0] rsvd;
        logic ss_level;
        logic miso_dir;
        logic ss_dir;
        logic sck_dir;
        logic mosi_dir;
    } pins_t;

    // one bit for each serial pad
    typedef struct packed {
        logic mosi;
        logic miso;
        logic sck;
        logic ss;
    } pad_t;

    // master clock generator states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW = 2'b01,
        ST_HIGH = 2'b10
    } state_t;

endpackage

//--- rtl/serial_peripheral_port.sv
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "serial_port_defs.svh"

// Summary of operation
// - a low select starts a transfer; the slave shifts only while select is low
// - master-out carries data to the slave, master-in back, both each clock
// - select high between packets resets the slave bit counter
// - as master the select pin is driven from software only
// - a data write in master mode starts the clock for exactly 8 bits
// - master clock stops after one byte and the completion flag sets
// - flag set with interrupt enable raises the interrupt in either mode
// - each finished byte is kept in the receive buffer
// - slave with select high stays idle, master-in output released
// - slave data may be written with select high; no shifting until low
// - slave flag sets after a full byte; next byte may be loaded early
// - data writes during a byte are refused: single transmit buffer
// - receive buffer overwritten by the next byte if not read
// - slave detects the serial clock by sampling it on the cpu clock
// - enabled port overrides pin directions per master or slave mode
// - bit order selectable: lsb first or msb first
// - master offers seven serial clock rates from the cpu clock
// - double speed with rate 0 gives a serial clock of the cpu clock over two
// - enable, master and rate bit 0 together give a clock of fck/16
// - a refused data write sets the write collision flag
// - the completion interrupt also raises the wake request
module serial_peripheral_port #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // serial pads
    input wire serial_port_pkg::pad_t pad_in,
    output serial_port_pkg::pad_t pad_out,
    output serial_port_pkg::pad_t pad_oe,
    // events
    output logic irq,
    output logic wake_req
);

    // ======================================================================
    // helpers
    // one-hot register select {pins, data, stat, ctrl}
    function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
        reg_sel = {a == ADDR_W'(`OFS_PINS), a == ADDR_W'(`OFS_DATA),
                   a == ADDR_W'(`OFS_STAT), a == ADDR_W'(`OFS_CTRL)};
    endfunction

    // bit that leaves the shifter next
    function automatic logic out_of(input logic [7:0] d, input logic lsb);
        out_of = lsb ? d[0] : d[7];
    endfunction

    // shift one received bit in at the far end
    function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b,
                                            input logic lsb);
        shift_in = lsb ? {b, d[7:1]} : {d[6:0], b};
    endfunction

    // half period of the serial clock in cpu cycles
    function automatic logic [6:0] half_of(input logic [1:0] r, input logic dbl);
        case ({dbl, r})
            3'b000: half_of = `HALF_N0;
            3'b001: half_of = `HALF_N1;
            3'b010: half_of = `HALF_N2;
            3'b011: half_of = `HALF_N3;
            3'b100: half_of = `HALF_D0;
            3'b101: half_of = `HALF_D1;
            3'b110: half_of = `HALF_D2;
            default: half_of = `HALF_D3;
        endcase
    endfunction

    // ======================================================================
    // state
    serial_port_pkg::ctrl_t ctrl_reg;
    serial_port_pkg::pins_t pins_reg;
    serial_port_pkg::state_t state_reg;
    logic dbl_reg, flag_reg, wcol_reg, armed_reg;
    logic [7:0] rx_buf_reg, shift_reg;
    logic out_bit_reg, sck_reg, sck_prev_reg;
    logic [3:0] cnt_reg;
    logic [6:0] div_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    // ======================================================================
    // bus decode
    logic wr_fire, rd_fire, wr_lane, master, slave_mode, slave_active, busy;
    logic wr_data, rd_data, rd_stat, data_load, collision, clear_ev;
    logic m_lead, m_trail, s_lead, s_trail, lead, trail, in_bit, done;
    logic [3:0] wsel, rsel;
    logic [6:0] half;
    logic [7:0] shift_nx;

    // both channels are taken together so the pair can never tear
    assign wr_fire = awvalid & wvalid & ~bvalid_reg;
    assign awready = wr_fire;
    assign wready = wr_fire;
    assign arready = ~rvalid_reg;
    assign rd_fire = arvalid & ~rvalid_reg;
    assign wsel = reg_sel(awaddr);
    assign rsel = reg_sel(araddr);
    assign wr_lane = wr_fire & wstrb[0];
    assign wr_data = wr_lane & wsel[2];
    assign rd_data = rd_fire & rsel[2];
    assign rd_stat = rd_fire & rsel[1];

    // mode decode and transfer events
    assign master = ctrl_reg.enable & ctrl_reg.master;
    assign slave_mode = ctrl_reg.enable & ~ctrl_reg.master;
    assign slave_active = slave_mode & ~pad_in.ss;
    assign busy = master ? (state_reg != serial_port_pkg::ST_IDLE) : (cnt_reg != 4'h0);
    assign data_load = wr_data & ~busy;
    assign collision = wr_data & busy;
    assign clear_ev = armed_reg & (rd_data | wr_data);
    assign half = half_of(ctrl_reg.rate, dbl_reg);
    assign m_lead = master & (state_reg == serial_port_pkg::ST_LOW) & (div_reg == 7'h00);
    assign m_trail = master & (state_reg == serial_port_pkg::ST_HIGH) & (div_reg == 7'h00);
    // sampled pin edges, never a clock of its own
    assign s_lead = slave_active & pad_in.sck & ~sck_prev_reg;
    assign s_trail = slave_active & ~pad_in.sck & sck_prev_reg;
    assign lead = m_lead | s_lead;
    assign trail = m_trail | s_trail;
    assign in_bit = master ? pad_in.miso : pad_in.mosi;
    assign shift_nx = shift_in(shift_reg, in_bit, ctrl_reg.lsb_first);
    assign done = (m_trail & (cnt_reg == `BYTE_BITS)) | (s_lead & (cnt_reg == `LAST_BIT));

    // ======================================================================
    // axi answers, one cycle after the request is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wsel != 4'h0) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // read data is captured when the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= (rsel != 4'h0) ? `RESP_OKAY : `RESP_SLVERR;
            case (rsel)
                4'b0001: rdata_reg <= {24'h00_0000, ctrl_reg};
                4'b0010: rdata_reg <= {24'h00_0000, flag_reg, wcol_reg, 5'h00, dbl_reg};
                4'b0100: rdata_reg <= {24'h00_0000, rx_buf_reg};
                4'b1000: rdata_reg <= {24'h00_0000, pins_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;

    // ======================================================================
    // software registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `CTRL_RST;
            pins_reg <= `PINS_RST;
            dbl_reg <= 1'b0;
        end else begin
            if (wr_lane & wsel[0])
                ctrl_reg <= wdata[7:0] & `CTRL_MASK;
            if (wr_lane & wsel[3])
                pins_reg <= wdata[7:0] & `PINS_MASK;
            if (wr_lane & wsel[1])
                dbl_reg <= wdata[`STAT_DBL];
        end
    end

    // flag pair: a new event in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_reg <= 1'b0;
            wcol_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            if (done)
                flag_reg <= 1'b1;
            else if (clear_ev)
                flag_reg <= 1'b0;
            if (collision)
                wcol_reg <= 1'b1;
            else if (clear_ev)
                wcol_reg <= 1'b0;
            if (rd_stat & (flag_reg | wcol_reg))
                armed_reg <= 1'b1;
            else if (clear_ev)
                armed_reg <= 1'b0;
        end
    end

    // ======================================================================
    // master clock generator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= serial_port_pkg::ST_IDLE;
            sck_reg <= 1'b0;
            div_reg <= 7'h00;
        end else if (!master) begin
            state_reg <= serial_port_pkg::ST_IDLE;
            sck_reg <= 1'b0;
            div_reg <= 7'h00;
        end else begin
            case (state_reg)
                serial_port_pkg::ST_IDLE: begin
                    if (data_load) begin
                        state_reg <= serial_port_pkg::ST_LOW;
                        div_reg <= half - 7'h01;
                    end
                end
                serial_port_pkg::ST_LOW: begin
                    if (div_reg == 7'h00) begin
                        sck_reg <= 1'b1;
                        div_reg <= half - 7'h01;
                        state_reg <= serial_port_pkg::ST_HIGH;
                    end else begin
                        div_reg <= div_reg - 7'h01;
                    end
                end
                serial_port_pkg::ST_HIGH: begin
                    if (div_reg == 7'h00) begin
                        sck_reg <= 1'b0;
                        div_reg <= half - 7'h01;
                        // stop after the eighth bit
                        state_reg <= (cnt_reg == `BYTE_BITS) ? serial_port_pkg::ST_IDLE
                                                              : serial_port_pkg::ST_LOW;
                    end else begin
                        div_reg <= div_reg - 7'h01;
                    end
                end
                default: state_reg <= serial_port_pkg::ST_IDLE;
            endcase
        end
    end

    // ======================================================================
    // shifter, bit counter and receive buffer
    always_ff @(posedge aclk) begin
        if (!aresetn)
            sck_prev_reg <= 1'b0;
        else
            sck_prev_reg <= pad_in.sck;
    end

    // transmit byte loaded only between bytes
    always_ff @(posedge aclk) begin
        if (!aresetn)
            shift_reg <= 8'h00;
        else if (data_load)
            shift_reg <= wdata[7:0];
        else if (lead)
            shift_reg <= shift_nx;
    end

    // select high aborts a partial slave byte
    always_ff @(posedge aclk) begin
        if (!aresetn)
            cnt_reg <= 4'h0;
        else if (!ctrl_reg.enable | (slave_mode & pad_in.ss))
            cnt_reg <= 4'h0;
        else if (s_lead)
            cnt_reg <= (cnt_reg == `LAST_BIT) ? 4'h0 : cnt_reg + 4'h1;
        else if (m_lead)
            cnt_reg <= cnt_reg + 4'h1;
        else if (done)
            cnt_reg <= 4'h0;
    end

    // new bit goes out on the trailing edge
    always_ff @(posedge aclk) begin
        if (!aresetn)
            out_bit_reg <= 1'b0;
        else if (data_load)
            out_bit_reg <= out_of(wdata[7:0], ctrl_reg.lsb_first);
        else if (trail)
            out_bit_reg <= out_of(shift_reg, ctrl_reg.lsb_first);
    end

    // unread bytes are simply overwritten
    always_ff @(posedge aclk) begin
        if (!aresetn)
            rx_buf_reg <= 8'h00;
        else if (done)
            rx_buf_reg <= master ? shift_reg : shift_nx;
    end

    // ======================================================================
    // pads and events
    assign pad_out.mosi = out_bit_reg;
    assign pad_out.miso = out_bit_reg;
    assign pad_out.sck = sck_reg;
    assign pad_out.ss = pins_reg.ss_level;

    // direction override only while enabled
    always_comb begin
        pad_oe.mosi = pins_reg.mosi_dir;
        pad_oe.sck = pins_reg.sck_dir;
        pad_oe.ss = pins_reg.ss_dir;
        pad_oe.miso = pins_reg.miso_dir;
        if (master) begin
            pad_oe.miso = 1'b0;
        end else if (slave_mode) begin
            pad_oe.mosi = 1'b0;
            pad_oe.sck = 1'b0;
            pad_oe.ss = 1'b0;
            pad_oe.miso = pins_reg.miso_dir & ~pad_in.ss;
        end
    end

    assign irq = ctrl_reg.irq_en & flag_reg;
    assign wake_req = irq;

    // ======================================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_flag_on_done: assert property (done |=> flag_reg)
        else $error("flag not set after byte");
    a_irq_on_flag: assert property ($rose(flag_reg) && ctrl_reg.irq_en |-> irq && wake_req)
        else $error("no interrupt on flag");
    a_miso_released: assert property (slave_mode && pad_in.ss |-> !pad_oe.miso)
        else $error("miso driven while deselected");
    a_slave_hold_data: assert property (slave_mode && pad_in.ss && !data_load
        |=> shift_reg == $past(shift_reg))
        else $error("shifter moved while deselected");
    a_refused_write: assert property (wr_data && busy
        |=> wcol_reg)
        else $error("collision not flagged");
    a_rx_capture: assert property (done && master |=> rx_buf_reg == $past(shift_reg))
        else $error("receive buffer not loaded");
    a_master_stops: assert property (m_trail && cnt_reg == `BYTE_BITS
        |=> state_reg == serial_port_pkg::ST_IDLE && flag_reg && !sck_reg)
        else $error("clock did not stop after eight bits");
    a_master_dirs: assert property (master |-> !pad_oe.miso)
        else $error("miso driven in master mode");
    a_slave_dirs: assert property (slave_mode |-> !pad_oe.mosi && !pad_oe.sck && !pad_oe.ss)
        else $error("slave drives an input pin");
    a_select_sw_only: assert property (!(wr_lane && wsel[3]) |=> $stable(pad_out.ss))
        else $error("select changed without software");
    a_flag_cleared: assert property (clear_ev && !done |=> !flag_reg)
        else $error("flag not cleared");
    a_double_speed: assert property (m_lead && half == `HALF_D0 |=> sck_reg ##1 !sck_reg)
        else $error("double speed period wrong");

    c_master_byte: cover property (master && done);
    c_slave_byte: cover property (slave_mode && done);
    c_collision: cover property (collision);
    c_clear: cover property (clear_ev && flag_reg);

endmodule

//--- test/spi_far_model.sv
`timescale 1ns/1ps

// ==========================================================================
// far device on the serial link: samples on sck rising, changes on falling
module spi_far_model (
    // serial wires
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss_n,
    output logic miso,
    // byte exchange with the bench
    input wire logic lsb_first,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    logic [7:0] sh;

    // quiet start before any frame
    initial begin
        miso = 1'b0;
        sh = 8'h00;
        rx_byte = 8'h00;
    end

    // low select opens a frame, first bit presented at once
    always @(negedge ss_n) begin
        sh = tx_byte;
        miso = lsb_first ? sh[0] : sh[7];
    end

    // released line has no pull, so show the inverse of the last level
    always @(posedge ss_n) begin
        miso = ~miso;
    end

    // both directions move on every clock
    always @(posedge sck) begin
        if (!ss_n) begin
            rx_byte = lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
        end
    end

    // next bit out on the falling edge
    always @(negedge sck) begin
        if (!ss_n) begin
            sh = lsb_first ? sh >> 1 : sh << 1;
            miso = lsb_first ? sh[0] : sh[7];
        end
    end
endmodule

//--- test/serial_peripheral_port_bench.sv
`timescale 1ns/1ps
`include "serial_port_defs.svh"

// ==========================================================================
// bench: axi4-lite master, far device, bench-made serial master for slave mode
module serial_peripheral_port_bench;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq, wake_req;
    logic [7:0] awaddr, araddr, far_tx, far_rx, tx, mrx;
    logic [31:0] wdata, rdata, rd_s;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, br_s, rr_s;
    logic sck_b, mosi_b, ss_b, far_miso, lsb_sel;
    serial_port_pkg::pad_t pad_in, pad_out, pad_oe;
    int n_fail, tests_run, cyc, t_take, c0, nsck, h;

    // wire levels: an enabled output wins, otherwise the outside party
    assign pad_in.sck = pad_oe.sck ? pad_out.sck : sck_b;
    assign pad_in.mosi = pad_oe.mosi ? pad_out.mosi : mosi_b;
    assign pad_in.miso = pad_oe.miso ? pad_out.miso : far_miso;
    assign pad_in.ss = pad_oe.ss ? pad_out.ss : ss_b;

    serial_peripheral_port #(.ADDR_W(8)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .irq(irq), .wake_req(wake_req));
    spi_far_model far_u (.sck(pad_in.sck), .mosi(pad_in.mosi), .ss_n(pad_in.ss),
        .miso(far_miso), .lsb_first(lsb_sel), .tx_byte(far_tx), .rx_byte(far_rx));

    always #2.5 aclk = ~aclk;
    always @(posedge pad_in.sck) nsck = nsck + 1;

    // ==========================================================================
    // cycle count; ceiling is ten times the slowest full run
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task results;
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========================================================================
    // bus cycles: outputs looked at mid-cycle so edge updates never race
    task automatic axw(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(negedge aclk); while (awready !== 1'b1);
        t_take = cyc;
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        do @(negedge aclk); while (bvalid !== 1'b1);
        br_s = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(negedge aclk); while (rvalid !== 1'b1);
        rd_s = rdata;
        rr_s = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    // serial master in the bench: low 4 and high 3 cycles, both above 2
    task automatic sbyte(input logic [7:0] m, output logic [7:0] s);
        s = 8'h00;
        for (int b = 0; b < 8; b++) begin
            @(posedge aclk) mosi_b <= lsb_sel ? m[b] : m[7-b];
            repeat (3) @(posedge aclk);
            s = lsb_sel ? {pad_in.miso, s[7:1]} : {s[6:0], pad_in.miso};
            sck_b <= 1'b1;
            repeat (3) @(posedge aclk);
            sck_b <= 1'b0;
        end
    endtask

    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0, 4'hf};
        {sck_b, mosi_b, ss_b, lsb_sel, far_tx} = {4'b0010, 8'h00};
        {n_fail, tests_run, cyc, nsck} = {32'd0, 32'd0, 32'd0, 32'd0};
        void'($urandom(32'h404b));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        // reset state and an unmapped place
        axr(`OFS_CTRL);
        chk("ctrl rst", rd_s, 32'h0);
        axr(`OFS_PINS);
        chk("pins rst", rd_s, 32'h10);
        chk("oe rst", {28'h0, pad_oe}, 32'h0);
        axr(8'h10);
        chk("unm rresp", {30'h0, rr_s}, 32'h2);
        chk("unm rdata", rd_s, 32'h0);
        axw(8'h14, 8'h55);
        chk("unm bresp", {30'h0, br_s}, 32'h2);
        // master: every rate, random order and bytes, edge bytes first
        axw(`OFS_PINS, 8'h07);
        for (int i = 0; i < 8; i++) begin
            h = (i % 4 == 0) ? 2 : (i % 4 == 1) ? 8 : (i % 4 == 2) ? 32 : 64;
            h = (i >= 4) ? h / 2 : h;
            lsb_sel = $urandom % 2;
            far_tx = $urandom;
            tx = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : 8'($urandom);
            axw(`OFS_STAT, 8'(i / 4));
            axw(`OFS_CTRL, 8'(8'hd0 | (lsb_sel << 5) | i % 4));
            // end the packet so the far device reloads its byte on the next select
            axw(`OFS_PINS, 8'h17);
            axw(`OFS_PINS, 8'h07);
            nsck = 0;
            axw(`OFS_DATA, tx);
            c0 = t_take;
            if (i == 0) axw(`OFS_DATA, 8'h3c);
            do @(negedge aclk); while (irq !== 1'b1);
            chk("flag time", cyc - c0, 16 * h + 1);
            chk("sck rises", nsck, 8);
            chk("far rx", far_rx, tx);
            chk("ss held", pad_in.ss, 0);
            chk("miso oe", pad_oe.miso, 0);
            chk("wake", wake_req, 1);
            axr(`OFS_STAT);
            chk("stat", rd_s, (i == 0 ? 32'hc0 : 32'h80) | i / 4);
            if (i % 2 == 1) begin
                axr(`OFS_DATA);
                chk("rx buf", rd_s, far_tx);
                chk("irq clr", irq, 0);
            end
        end
        axw(`OFS_PINS, 8'h17);
        chk("ss end", pad_in.ss, 1);
        // slave: clocks with select high do nothing, then two bytes back to back
        lsb_sel = $urandom % 2;
        axw(`OFS_STAT, 8'h00);
        axw(`OFS_CTRL, 8'(8'hc0 | (lsb_sel << 5)));
        axw(`OFS_PINS, 8'h08);
        sbyte(8'ha5, mrx);
        chk("idle irq", irq, 0);
        chk("idle oe", {28'h0, pad_oe}, 32'h0);
        for (int j = 0; j < 2; j++) begin
            tx = $urandom;
            far_tx = $urandom;
            axw(`OFS_DATA, tx);
            @(posedge aclk) ss_b <= 1'b0;
            sbyte(far_tx, mrx);
            do @(negedge aclk); while (irq !== 1'b1);
            chk("slv miso", mrx, tx);
            chk("slv oe", {28'h0, pad_oe}, 32'h4);
            axr(`OFS_STAT);
            chk("slv stat", rd_s, 32'h80);
            if (j == 1) begin
                axr(`OFS_DATA);
                chk("slv rx", rd_s, far_tx);
            end
        end
        @(posedge aclk) ss_b <= 1'b1;
        @(negedge aclk);
        chk("slv rel", pad_oe.miso, 0);
        results();
    end
endmodule
